// ===== rtl/shift_ctl_exec.sv
// Shift and control instruction executor with its register bank, program counter,
// status indicators, operations monitor timer and a Wishbone classic register slave.
// Assumes software issues one instruction at a time and pins are asynchronous.
//
// Operation
// - Bits 7..5 of a shift pick one of eight general registers, 000 first.
// - Fetch phase two loads working and operand latches, advances PC, clears counter.
// - Each pass writes working bits 15..1 to destination 14..0, bit 0 to carry.
// - Without end-of-shift, reload working latch and shift again; else terminate.
// - Arithmetic shift keeps bit 15 equal to the previous sign.
// - Rotate shift puts working bit 0 into bit 15 and into carry.
// - Logical count shift inserts zero; ends on count or carry one.
// - Rotate through carry moves carry into bit 15, bit 0 into carry.
// - Shifts update zero, plus and carry from the result.
// - Execute phase four copies PC into the address latch and returns to idle.
// - Control instructions load latches, advance PC, then go to execute phase three.
// - Sync pulse drives the sync line 240 ns, or 180 ns under fast ROM.
// - Monitor timer stays idle until the first kick; each kick restarts it.
// - Kicks must come within 192 ms; otherwise the monitor alarm fires.
// - The alarm forces idle mode and drops the safe line.
// - Carry clear clears the carry, carry set sets it, in phase three.
// - Background select clears the foreground flag; background bank is used.
// - Without the foreground/background option the bank is always background.
// - Foreground select sets the foreground flag; foreground bank is used.
// - Reset sets the foreground flag, whether or not the option is installed.
// - Interrupt inhibit clears the enable; power-fail and restart stay unmaskable.
// - Interrupt enable sets the enable, letting any asserted maskable request through.
// - After each increment, counter equal to instruction count raises end-of-shift.
`timescale 1ns/100ps
`default_nettype none

module shift_ctl_exec
  import shift_ctl_pkg::*;
#(
  parameter int OMA_LIMIT = shift_ctl_pkg::OMA_CYCLES
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire shift_ctl_pkg::wb_req_t wb_req,
  output var shift_ctl_pkg::wb_rsp_t wb_rsp,
  input wire logic fast_rom,
  input wire logic fgbg_option,
  input wire logic [2:0] irq_maskable,
  input wire logic [1:0] irq_unmaskable,
  output logic sync_out,
  output logic safe_output_line,
  output logic run_mode,
  output logic irq_take
);
  import shift_ctl_pkg::*;

  localparam int PINS = 7;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_FETCH_TWO,
    PH_EXEC_TWO,
    PH_EXEC_THREE,
    PH_EXEC_FOUR
  } phase_t;

  typedef struct packed {
    phase_t phase;
    logic [15:0] instr;
    logic [15:0] pc;
    logic [15:0] laddr;
    logic [15:0] work;
    logic [15:0] operand;
    logic [3:0] shift_counter;
    logic link;
    logic zero;
    logic plus;
    logic foreground_flag;
    logic irq_system_enable;
    logic run;
    logic alarm;
    logic armed;
    logic refused;
    logic [31:0] oma_count;
    logic [7:0] pulse_count;
    logic sync;
    logic irq;
    logic [15:0][15:0] gpr;
    logic [PINS-1:0] s1;
    logic [PINS-1:0] s2;
    logic [PINS-1:0] s3;
    logic [PINS-1:0] filt;
    logic ack;
    logic [31:0] rdata;
  } core_t;

  core_t core_reg;
  core_t core_next;
  logic [PINS-1:0] pins;
  logic [PINS-1:0] filt_next;

  assign pins = {irq_unmaskable, irq_maskable, fgbg_option, fast_rom};

  // A pin change counts only once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++)
    begin : g_pin
      assign filt_next[gi] = (core_reg.s2[gi] == core_reg.s3[gi]) ? core_reg.s3[gi]
                                                                  : core_reg.filt[gi];
    end
  endgenerate

  // Merge a 16-bit register with the enabled low byte lanes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0])
      res[7:0] = dat[7:0];
    if (sel[1])
      res[15:8] = dat[15:8];
    return res;
  endfunction : merge16

  // Combinational next state: pins, bus slave, sequencer and monitor timer
  always_comb
  begin
    logic bank;
    logic [3:0] rd;
    logic [1:0] kind;
    logic [2:0] csel;
    logic is_shift;
    logic [15:0] shifted;
    logic [3:0] sc_inc;
    logic end_of_shift;
    logic [7:0] pulse_limit;
    logic access;
    logic kick;
    logic alarm_set;
    logic alarm_clear;
    logic refuse_set;
    logic refuse_clear;
    logic [31:0] status;
    core_next = core_reg;
    core_next.s1 = pins;
    core_next.s2 = core_reg.s1;
    core_next.s3 = core_reg.s2;
    core_next.filt = filt_next;
    bank = core_reg.foreground_flag & core_reg.filt[1];
    rd = {bank, core_reg.instr[DEST_LSB +: 3]};
    kind = core_reg.instr[KIND_LSB +: 2];
    csel = core_reg.instr[2:0];
    is_shift = (core_reg.instr[GROUP_LSB +: 4] == GROUP_SHIFT);
    shifted = {1'b0, core_reg.work[15:1]};
    sc_inc = core_reg.shift_counter + 4'h1;
    end_of_shift = 1'b0;
    pulse_limit = core_reg.filt[0] ? 8'(SYNC_FAST_CYCLES) : 8'(SYNC_CYCLES);
    access = wb_req.cyc & wb_req.stb & ~core_reg.ack;
    kick = 1'b0;
    alarm_set = 1'b0;
    alarm_clear = 1'b0;
    refuse_set = 1'b0;
    refuse_clear = 1'b0;
    status = 32'h0000_0000;
    status[ST_BUSY] = (core_reg.phase != PH_IDLE);
    status[ST_LINK] = core_reg.link;
    status[ST_ZERO] = core_reg.zero;
    status[ST_PLUS] = core_reg.plus;
    status[ST_FOREGROUND] = core_reg.foreground_flag;
    status[ST_ISE] = core_reg.irq_system_enable;
    status[ST_ALARM] = core_reg.alarm;
    status[ST_ARMED] = core_reg.armed;
    status[ST_RUN] = core_reg.run;
    status[ST_REFUSED] = core_reg.refused;
    status[ST_BANK] = bank;
    status[ST_SC_LSB +: 4] = core_reg.shift_counter;

    // Bus slave: ack one cycle after the strobe; unmapped reads return zero
    core_next.ack = access;
    core_next.rdata = 32'h0000_0000;
    if (access)
    begin
      if (!wb_req.we)
      begin
        if (wb_req.adr == ADDR_INSTR)
          core_next.rdata = {16'h0000, core_reg.instr};
        else if (wb_req.adr == ADDR_CTRL)
          core_next.rdata = {31'h0000_0000, core_reg.run};
        else if (wb_req.adr == ADDR_STATUS)
          core_next.rdata = status;
        else if (wb_req.adr == ADDR_PC)
          core_next.rdata = {16'h0000, core_reg.pc};
        else if (wb_req.adr == ADDR_LATCH)
          core_next.rdata = {core_reg.operand, core_reg.laddr}; // Operand latch rides along
        else if (wb_req.adr[7:6] == ADDR_GPR[7:6])
          core_next.rdata = {16'h0000, core_reg.gpr[wb_req.adr[5:2]]};
      end
      else if (wb_req.adr == ADDR_INSTR)
      begin
        // Instructions are taken only when idle, in run mode, and of a known group
        if (core_reg.phase == PH_IDLE && core_reg.run && wb_req.sel[1:0] == 2'h3 &&
            (wb_req.dat[GROUP_LSB +: 4] == GROUP_SHIFT ||
             wb_req.dat[GROUP_LSB +: 4] == GROUP_CONTROL))
        begin
          core_next.instr = wb_req.dat[15:0];
          core_next.phase = PH_FETCH_TWO;
        end
        else
          refuse_set = 1'b1;
      end
      else if (wb_req.adr == ADDR_CTRL && wb_req.sel[0])
      begin
        core_next.run = wb_req.dat[CTRL_RUN];
        alarm_clear = wb_req.dat[CTRL_ALARM_CLEAR];
        refuse_clear = wb_req.dat[CTRL_REFUSED_CLEAR];
      end
      else if (core_reg.phase == PH_IDLE)
      begin
        // The PC and the register bank are only written between instructions
        if (wb_req.adr == ADDR_PC)
          core_next.pc = merge16(core_reg.pc, wb_req.dat, wb_req.sel);
        else if (wb_req.adr[7:6] == ADDR_GPR[7:6])
          core_next.gpr[wb_req.adr[5:2]] =
            merge16(core_reg.gpr[wb_req.adr[5:2]], wb_req.dat, wb_req.sel);
      end
    end

    // Instruction sequencer
    case (core_reg.phase)
      PH_IDLE:
      begin
        core_next.pulse_count = 8'h00;
      end
      PH_FETCH_TWO:
      begin
        core_next.work = core_reg.gpr[rd];
        core_next.operand = core_reg.gpr[rd];
        core_next.pc = core_reg.pc + 16'h0001 + {15'h0000, core_reg.irq_system_enable};
        core_next.pulse_count = 8'h00;
        if (is_shift)
          core_next.shift_counter = 4'h0;
        else if (csel == SYNC_PULSE_INSTR)
          core_next.sync = 1'b1;
        core_next.phase = PH_EXEC_THREE;
      end
      PH_EXEC_TWO:
      begin
        // Reload from the destination for the next pass
        core_next.work = core_reg.gpr[rd];
        core_next.phase = PH_EXEC_THREE;
      end
      PH_EXEC_THREE:
      begin
        if (is_shift)
        begin
          case (kind)
            SHIFT_RIGHT_ARITH: shifted[15] = core_reg.work[15];
            SHIFT_RIGHT_ROTATE: shifted[15] = core_reg.work[0];
            SHIFT_RIGHT_LOGICAL_COUNT: shifted[15] = 1'b0;
            ROTATE_THROUGH_CARRY: shifted[15] = core_reg.link;
            default: shifted[15] = 1'b0;
          endcase
          core_next.gpr[rd] = shifted;
          core_next.link = core_reg.work[0];
          core_next.zero = (shifted == 16'h0000);
          core_next.plus = ~shifted[15];
          core_next.shift_counter = sc_inc;
          // Count zero wraps the counter, giving sixteen passes
          end_of_shift = (sc_inc == core_reg.instr[COUNT_LSB +: 4]);
          if (kind == SHIFT_RIGHT_LOGICAL_COUNT && core_reg.work[0])
            end_of_shift = 1'b1;
          core_next.phase = end_of_shift ? PH_EXEC_FOUR : PH_EXEC_TWO;
        end
        else
        begin
          core_next.phase = PH_EXEC_FOUR;
          case (csel)
            SYNC_PULSE_INSTR:
            begin
              // Hold phase three for the whole pulse width
              core_next.pulse_count = core_reg.pulse_count + 8'h01;
              if (core_reg.pulse_count == pulse_limit - 8'h01)
                core_next.sync = 1'b0;
              else
                core_next.phase = PH_EXEC_THREE;
            end
            MONITOR_KICK_INSTR: kick = 1'b1;
            CARRY_CLEAR_INSTR: core_next.link = 1'b0;
            CARRY_SET_INSTR: core_next.link = 1'b1;
            BACKGROUND_SELECT_INSTR: core_next.foreground_flag = 1'b0;
            FOREGROUND_SELECT_INSTR: core_next.foreground_flag = 1'b1;
            IRQ_INHIBIT_INSTR: core_next.irq_system_enable = 1'b0;
            IRQ_ENABLE_INSTR: core_next.irq_system_enable = 1'b1;
            default: core_next.phase = PH_EXEC_FOUR;
          endcase
        end
      end
      PH_EXEC_FOUR:
      begin
        core_next.laddr = core_reg.pc;
        core_next.phase = PH_IDLE;
      end
      default:
      begin
        core_next.phase = PH_IDLE;
      end
    endcase

    // Operations monitor: idle until armed, restarted by every kick
    if (kick)
    begin
      core_next.armed = 1'b1;
      core_next.oma_count = 32'h0000_0000;
    end
    else if (core_reg.armed)
    begin
      core_next.oma_count = core_reg.oma_count + 32'h0000_0001;
      if (core_reg.oma_count == 32'(OMA_LIMIT - 1))
      begin
        alarm_set = 1'b1;
        core_next.armed = 1'b0;
      end
    end

    // The alarm drops run mode; a new alarm wins over a clear in the same cycle
    if (alarm_set)
    begin
      core_next.alarm = 1'b1;
      core_next.run = 1'b0;
    end
    else if (alarm_clear)
      core_next.alarm = 1'b0;
    if (refuse_set)
      core_next.refused = 1'b1;
    else if (refuse_clear)
      core_next.refused = 1'b0;

    // Maskable requests pass only with the enable; power-fail and restart always do
    core_next.irq = (core_reg.irq_system_enable & (|core_reg.filt[4:2])) |
                    (|core_reg.filt[6:5]);
  end

  // One register stage for all state
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      core_reg <= '0;
      core_reg.phase <= PH_IDLE;
      core_reg.pc <= PC_RESET;
      core_reg.run <= RUN_RESET;
      core_reg.foreground_flag <= FOREGROUND_RESET;
      core_reg.irq_system_enable <= ISE_RESET;
    end
    else
      core_reg <= core_next;
  end

  // Outputs straight from flip-flops
  assign wb_rsp.ack = core_reg.ack;
  assign wb_rsp.dat = core_reg.rdata;
  assign sync_out = core_reg.sync;
  assign safe_output_line = ~core_reg.alarm;
  assign run_mode = core_reg.run;
  assign irq_take = core_reg.irq;

endmodule : shift_ctl_exec

`default_nettype wire

// ===== rtl/shift_ctl_pkg.sv
// Constants, instruction encodings and bus carriers for the shift and control executor.
// Assumes a 100 MHz phase clock and a classic Wishbone master with 32-bit data.
package shift_ctl_pkg;

  // Clock rate and timing figures
  localparam int CLOCK_MHZ = 100;
  localparam int SYNC_NS = 240;
  localparam int SYNC_FAST_NS = 180;
  localparam int OMA_MS = 192;
  // Longest times round down to whole cycles
  localparam int SYNC_CYCLES = SYNC_NS * CLOCK_MHZ / 1000;
  localparam int SYNC_FAST_CYCLES = SYNC_FAST_NS * CLOCK_MHZ / 1000;
  localparam int OMA_CYCLES = OMA_MS * CLOCK_MHZ * 1000;

  // Register byte offsets
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_PC = 8'h0C;
  localparam logic [7:0] ADDR_LATCH = 8'h10;
  localparam logic [7:0] ADDR_GPR = 8'h40;

  // Reset values
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic RUN_RESET = 1'b0;
  localparam logic FOREGROUND_RESET = 1'b1;
  localparam logic ISE_RESET = 1'b0;

  // Control register fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_ALARM_CLEAR = 1;
  localparam int CTRL_REFUSED_CLEAR = 2;

  // Status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_LINK = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_PLUS = 3;
  localparam int ST_FOREGROUND = 4;
  localparam int ST_ISE = 5;
  localparam int ST_ALARM = 6;
  localparam int ST_ARMED = 7;
  localparam int ST_RUN = 8;
  localparam int ST_REFUSED = 9;
  localparam int ST_BANK = 10;
  localparam int ST_SC_LSB = 12;

  // Instruction word fields
  localparam int GROUP_LSB = 12;
  localparam int KIND_LSB = 8;
  localparam int DEST_LSB = 5;
  localparam int COUNT_LSB = 0;
  localparam logic [3:0] GROUP_SHIFT = 4'h1;
  localparam logic [3:0] GROUP_CONTROL = 4'h2;

  // Shift variants
  localparam logic [1:0] SHIFT_RIGHT_ARITH = 2'h0;
  localparam logic [1:0] SHIFT_RIGHT_ROTATE = 2'h1;
  localparam logic [1:0] SHIFT_RIGHT_LOGICAL_COUNT = 2'h2;
  localparam logic [1:0] ROTATE_THROUGH_CARRY = 2'h3;

  // Control instructions
  localparam logic [2:0] SYNC_PULSE_INSTR = 3'h0;
  localparam logic [2:0] MONITOR_KICK_INSTR = 3'h1;
  localparam logic [2:0] CARRY_CLEAR_INSTR = 3'h2;
  localparam logic [2:0] CARRY_SET_INSTR = 3'h3;
  localparam logic [2:0] BACKGROUND_SELECT_INSTR = 3'h4;
  localparam logic [2:0] FOREGROUND_SELECT_INSTR = 3'h5;
  localparam logic [2:0] IRQ_INHIBIT_INSTR = 3'h6;
  localparam logic [2:0] IRQ_ENABLE_INSTR = 3'h7;

  // Wishbone carriers
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

endpackage : shift_ctl_pkg

// ===== test/shift_ctl_checker.sv
// Port-level checker for the shift and control executor.
// Assumes it is bound to shift_ctl_exec and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module shift_ctl_checker
  import shift_ctl_pkg::*;
#(
  parameter int OMA_LIMIT = shift_ctl_pkg::OMA_CYCLES
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire shift_ctl_pkg::wb_req_t wb_req,
  input wire shift_ctl_pkg::wb_rsp_t wb_rsp,
  input wire logic fast_rom,
  input wire logic fgbg_option,
  input wire logic [2:0] irq_maskable,
  input wire logic [1:0] irq_unmaskable,
  input wire logic sync_out,
  input wire logic safe_output_line,
  input wire logic run_mode,
  input wire logic irq_take
);
  int sync_len_reg;

  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // Counts high cycles of the sync pulse; too long for a plain repetition
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      sync_len_reg <= 0;
    else
      sync_len_reg <= sync_out ? sync_len_reg + 1 : 0;
  end

  sync_max_a: assert property (sync_out |-> sync_len_reg < SYNC_CYCLES)
    else $error("sync pulse runs too long");
  sync_width_a: assert property ($fell(sync_out) |->
    (sync_len_reg == SYNC_CYCLES || sync_len_reg == SYNC_FAST_CYCLES))
    else $error("sync pulse width wrong");
  sync_start_a: assert property ($rose(sync_out) |-> $past(wb_rsp.ack))
    else $error("sync pulse not right after fetch");
  alarm_idle_a: assert property ($fell(safe_output_line) |-> ##[0:1] !run_mode)
    else $error("alarm left run mode on");
  safe_hold_a: assert property ((!safe_output_line) [*2] |-> !run_mode)
    else $error("run mode while safe line low");
  reset_out_a: assert property ($rose(rstn) |->
    safe_output_line && !run_mode && !sync_out && !irq_take)
    else $error("outputs wrong at reset release");
  irq_hard_a: assert property ((irq_unmaskable != 2'h0) [*8] |-> irq_take)
    else $error("unmaskable request not taken");
  irq_quiet_a: assert property
    ((irq_maskable == 3'h0 && irq_unmaskable == 2'h0) [*8] |-> !irq_take)
    else $error("interrupt taken with no request");
endmodule : shift_ctl_checker

bind shift_ctl_exec shift_ctl_checker #(.OMA_LIMIT(OMA_LIMIT)) chk_u (
  .clock(clock), .rstn(rstn), .wb_req(wb_req), .wb_rsp(wb_rsp), .fast_rom(fast_rom),
  .fgbg_option(fgbg_option), .irq_maskable(irq_maskable), .irq_unmaskable(irq_unmaskable),
  .sync_out(sync_out), .safe_output_line(safe_output_line), .run_mode(run_mode),
  .irq_take(irq_take)
);
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the shift and control executor.
// Assumes the Wishbone register map of shift_ctl_pkg and a short monitor limit.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import shift_ctl_pkg::*;
  localparam int LIMIT = 200;
  typedef struct {logic [15:0] instr; logic cin; logic [15:0] din, dout; logic cout;
    logic [3:0] sc;} row_t;
  logic clock, rstn, fast_rom, fgbg_option, sync_out, safe_output_line, run_mode, irq_take;
  logic [2:0] irq_maskable;
  logic [1:0] irq_unmaskable;
  wb_req_t wb_req;
  wb_rsp_t wb_rsp;
  logic [31:0] rd, pc0;
  logic [7:0] a;
  int n_fail = 0;
  int checks = 0;
  int sync_hi = 0;
  int s0;
  // Shift cases: instruction, carry in, value in, value out, carry out, counter
  row_t rows [6] = '{
    '{16'h1004, 1'b0, 16'h8010, 16'hF801, 1'b0, 4'h4},
    '{16'h11E1, 1'b0, 16'h0003, 16'h8001, 1'b1, 4'h1},
    '{16'h126F, 1'b0, 16'hF0F0, 16'h0787, 1'b1, 4'h5},
    '{16'h1342, 1'b1, 16'h0001, 16'hC000, 1'b0, 4'h2},
    '{16'h1020, 1'b0, 16'h4000, 16'h0000, 1'b0, 4'h0},
    '{16'h1283, 1'b0, 16'h0008, 16'h0001, 1'b0, 4'h3}
  };

  shift_ctl_exec #(.OMA_LIMIT(LIMIT)) dut_u (.clock(clock), .rstn(rstn), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .fast_rom(fast_rom), .fgbg_option(fgbg_option),
    .irq_maskable(irq_maskable), .irq_unmaskable(irq_unmaskable), .sync_out(sync_out),
    .safe_output_line(safe_output_line), .run_mode(run_mode), .irq_take(irq_take));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Own count of sync high cycles, independent of the checker
  always @(posedge clock) if (sync_out === 1'b1) sync_hi <= sync_hi + 1;

  task summarize;
    $display("errors %0d checks %0d", n_fail, checks);
    if (n_fail == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One classic cycle; request held until ack is sampled high
  task wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge clock);
    wb_req <= '{1'b1, 1'b1, w, 4'h3, ad, d};
    for (n = 0; n < 20 && wb_rsp.ack !== 1'b1; n++) @(posedge clock);
    if (n == 20)
    begin
      n_fail++;
      summarize();
    end
    rd = wb_rsp.dat;
    wb_req <= '0;
  endtask : wb

  // Issue an instruction and poll busy, bounded
  task exec(input logic [15:0] i);
    int n;
    wb(1'b1, ADDR_INSTR, {16'h0, i});
    for (n = 0; n < 100; n++)
    begin
      wb(1'b0, ADDR_STATUS, 32'h0);
      if (rd[ST_BUSY] === 1'b0) break;
    end
    if (n == 100)
    begin
      n_fail++;
      summarize();
    end
  endtask : exec

  function automatic logic [15:0] ctl(input logic [2:0] c);
    return {GROUP_CONTROL, 9'h0, c};
  endfunction : ctl

  initial
  begin
    rstn = 1'b0;
    fast_rom = 1'b0;
    fgbg_option = 1'b1;
    irq_maskable = 3'h0;
    irq_unmaskable = 2'h0;
    wb_req = '0;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    repeat (6) @(posedge clock);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'({rd[ST_FOREGROUND], rd[ST_BANK], rd[ST_ISE], rd[ST_RUN]}), 32'hC);
    // Not running yet, so the instruction must be refused and carry left alone
    exec(ctl(CARRY_SET_INSTR));
    chk(32'({rd[ST_REFUSED], rd[ST_LINK]}), 32'h2);
    wb(1'b1, ADDR_CTRL, 32'h5);
    foreach (rows[k])
    begin
      a = ADDR_GPR | {2'b00, 1'b1, rows[k].instr[7:5], 2'b00};
      wb(1'b1, a, {16'h0, rows[k].din});
      exec(ctl(rows[k].cin ? CARRY_SET_INSTR : CARRY_CLEAR_INSTR));
      exec(rows[k].instr);
      chk(32'({rd[ST_SC_LSB+:4], rd[ST_ZERO], rd[ST_PLUS], rd[ST_LINK]}),
        32'({rows[k].sc, !rows[k].dout, ~rows[k].dout[15], rows[k].cout}));
      wb(1'b0, a, 32'h0);
      chk(rd, {16'h0, rows[k].dout});
    end
    // Program counter steps by one, then by two once interrupts are enabled
    wb(1'b0, ADDR_PC, 32'h0);
    pc0 = rd;
    exec(ctl(IRQ_ENABLE_INSTR));
    exec(ctl(CARRY_CLEAR_INSTR));
    chk(32'({rd[ST_ISE], rd[ST_LINK]}), 32'h2);
    wb(1'b0, ADDR_PC, 32'h0);
    chk(rd, pc0 + 32'h3);
    wb(1'b0, ADDR_LATCH, 32'h0);
    // Upper half shows the operand latch, loaded from destination 0 of the foreground bank
    chk(rd, {rows[0].dout, 16'(pc0 + 32'h3)});
    irq_maskable <= 3'h4;
    repeat (10) @(posedge clock);
    chk(32'(irq_take), 32'h1);
    exec(ctl(IRQ_INHIBIT_INSTR));
    repeat (10) @(posedge clock);
    chk(32'(irq_take), 32'h0);
    irq_unmaskable <= 2'h2;
    repeat (10) @(posedge clock);
    chk(32'(irq_take), 32'h1);
    irq_maskable <= 3'h0;
    irq_unmaskable <= 2'h0;
    for (int f = 0; f < 2; f++)
    begin
      fast_rom <= f[0];
      repeat (6) @(posedge clock);
      s0 = sync_hi;
      exec(ctl(SYNC_PULSE_INSTR));
      chk(32'(sync_hi - s0), f ? SYNC_FAST_CYCLES : SYNC_CYCLES);
    end
    // Background bank must leave the foreground copy of register 0 untouched
    exec(ctl(BACKGROUND_SELECT_INSTR));
    chk(32'({rd[ST_FOREGROUND], rd[ST_BANK]}), 32'h0);
    wb(1'b1, ADDR_GPR, 32'h2);
    exec(16'h1001);
    wb(1'b0, ADDR_GPR, 32'h0);
    chk(rd, 32'h1);
    wb(1'b0, ADDR_GPR | 8'h20, 32'h0);
    chk(rd, 32'hF801);
    exec(ctl(FOREGROUND_SELECT_INSTR));
    chk(32'({rd[ST_FOREGROUND], rd[ST_BANK]}), 32'h3);
    fgbg_option <= 1'b0;
    repeat (6) @(posedge clock);
    exec(ctl(FOREGROUND_SELECT_INSTR));
    chk(32'(rd[ST_BANK]), 32'h0);
    fgbg_option <= 1'b1;
    // Monitor: idle before the first kick, restarted by each kick
    repeat (LIMIT + 50) @(posedge clock);
    chk(32'({safe_output_line, run_mode}), 32'h3);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'({rd[ST_ARMED], rd[ST_ALARM]}), 32'h0);
    exec(ctl(MONITOR_KICK_INSTR));
    chk(32'({rd[ST_ARMED], rd[ST_ALARM]}), 32'h2);
    repeat (150) @(posedge clock);
    exec(ctl(MONITOR_KICK_INSTR));
    repeat (150) @(posedge clock);
    chk(32'({safe_output_line, run_mode}), 32'h3);
    repeat (100) @(posedge clock);
    chk(32'({safe_output_line, run_mode}), 32'h0);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'({rd[ST_ALARM], rd[ST_ARMED], rd[ST_RUN]}), 32'h4);
    wb(1'b1, ADDR_CTRL, 32'h2);
    repeat (2) @(posedge clock);
    chk(32'(safe_output_line), 32'h1);
    summarize();
  end
endmodule : tb
`default_nettype wire
